// ---- verilog/csp_pkg.sv ----
`default_nettype none
package csp_pkg;
   // Clock rates
   localparam int CORE_PERIOD_NS = 100;
   localparam int SCLK_PERIOD_NS = 800;
   localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CORE_PERIOD_NS);
   localparam logic [2:0] SCLK_HALF_LAST = 3'(SCLK_HALF_CYC - 1);

   // Field widths and types
   localparam int ADDR_W = 5;
   localparam int BYTE_W = 8;
   localparam int NUM_REGS = 32;
   localparam int MAX_BYTES = 4;
   typedef logic [ADDR_W-1:0] csp_addr_t;
   typedef logic [BYTE_W-1:0] csp_byte_t;
   typedef logic [2:0] csp_bit_t;
   typedef logic [1:0] csp_cnt_t;
   localparam csp_bit_t BIT_LAST = 3'h7;

   // Instruction header layout
   localparam int INSTR_DIR_BIT = 7;
   localparam int INSTR_CNT_HI = 6;
   localparam int INSTR_CNT_LO = 5;

   // Port options register
   localparam csp_addr_t OPT_REG_ADDR = 5'h00;
   localparam int OPT_FOUR_WIRE_BIT = 7;
   localparam int OPT_LSB_FIRST_BIT = 6;
   localparam csp_byte_t OPT_WRITE_MASK = 8'hC0;
   localparam csp_byte_t REG_RESET = 8'h00;

   // Synchroniser reset levels: device {select, clock, data}, host {data, output pin}
   localparam logic [2:0] DEV_SYNC_RST = 3'h5;
   localparam logic [1:0] HOST_SYNC_RST = 2'h3;

   typedef enum logic [2:0] {
      DEV_IDLE = 3'b000,
      DEV_INSTR = 3'b001,
      DEV_WDATA = 3'b011,
      DEV_RDATA = 3'b010,
      DEV_WAIT = 3'b110
   } csp_dev_state_t;

   typedef enum logic [2:0] {
      HST_IDLE = 3'b000,
      HST_SETUP = 3'b001,
      HST_LOW = 3'b011,
      HST_HIGH = 3'b010,
      HST_END = 3'b110
   } csp_host_state_t;
endpackage
`default_nettype wire

// ---- verilog/csp_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface csp_if;
   logic sclk;
   logic port_select_n;
   logic data_io_h_o;
   logic data_io_h_oe;
   logic data_io_d_o;
   logic data_io_d_oe;
   logic serial_data_out_pin_o;
   logic serial_data_out_pin_oe;
   logic data_io;
   logic serial_data_out_pin;

   // Pulled up when nobody drives
   assign data_io = data_io_d_oe ? data_io_d_o : (data_io_h_oe ? data_io_h_o : 1'b1);
   assign serial_data_out_pin = serial_data_out_pin_oe ? serial_data_out_pin_o : 1'b1;

   modport device (
      input sclk,
      input port_select_n,
      input data_io,
      output data_io_d_o,
      output data_io_d_oe,
      output serial_data_out_pin_o,
      output serial_data_out_pin_oe
   );

   modport host (
      output sclk,
      output port_select_n,
      output data_io_h_o,
      output data_io_h_oe,
      input data_io,
      input serial_data_out_pin
   );
endinterface
`default_nettype wire

// ---- verilog/csp_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module csp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_q <= RST_VAL;
         q <= RST_VAL;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ---- verilog/csp_device.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Four-wire bit sends reads to output pin
// - Output pin driven only while shifting data
// - Every transaction opens with instruction byte
// - Header top bit: one read, zero write
// - Next two bits give byte count minus one
// - Low five bits give register address
// - Data follows header with no gap
// - Options bit six selects bit order
// - MSB first: address decrements per byte
// - LSB first: header and data LSB first
// - LSB first: address increments per byte
// - Header sampled on rising clock edges
// - Write bytes captured on rising edges
// - Host holds select low whole transaction
// - Read bits driven on falling edges
// - Three-wire read keeps output pin released
// - Four-wire read never drives data pin
// - Select high releases both pins
// - Host writes zero to undefined bits
module csp_device (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Serial link
   csp_if.device link,
   // Register lookup
   input wire csp_pkg::csp_addr_t look_addr,
   output csp_pkg::csp_byte_t look_data_q,
   // Write notification
   output logic wr_stb_q,
   output csp_pkg::csp_addr_t wr_addr_q,
   output csp_pkg::csp_byte_t wr_data_q,
   // Port options
   output logic four_wire,
   output logic lsb_first
);
   logic [2:0] raw, syn;
   logic sel_n, sclk_s, din;
   logic sclk_prev_q;
   logic rise, fall;
   logic byte_end, instr_end, wr_end, rd_end;
   csp_pkg::csp_dev_state_t state_q;
   csp_pkg::csp_bit_t bit_cnt_q;
   csp_pkg::csp_cnt_t left_q;
   csp_pkg::csp_addr_t addr_q, next_addr;
   csp_pkg::csp_byte_t in_byte, sh_q, rsh_q;
   csp_pkg::csp_byte_t regs_q [csp_pkg::NUM_REGS];
   logic last_q, out_q;
   logic data_io_oe_q, out_pin_oe_q;

   // Pins come from another domain
   assign raw = {link.port_select_n, link.sclk, link.data_io};

   csp_sync #(.W(3), .RST_VAL(csp_pkg::DEV_SYNC_RST)) u_sync (
      .clk(core_clk), .rst(rst),
      .d(raw), .q(syn)
   );

   assign sel_n = syn[2];
   assign sclk_s = syn[1];
   assign din = syn[0];
   assign rise = sclk_s & ~sclk_prev_q;
   assign fall = ~sclk_s & sclk_prev_q;

   assign four_wire = regs_q[csp_pkg::OPT_REG_ADDR][csp_pkg::OPT_FOUR_WIRE_BIT];
   assign lsb_first = regs_q[csp_pkg::OPT_REG_ADDR][csp_pkg::OPT_LSB_FIRST_BIT];

   assign in_byte = lsb_first ? {din, sh_q[7:1]} : {sh_q[6:0], din};
   assign next_addr = lsb_first ? addr_q + 1'b1 : addr_q - 1'b1;

   assign byte_end = bit_cnt_q == csp_pkg::BIT_LAST;
   assign instr_end = state_q == csp_pkg::DEV_INSTR && rise && byte_end;
   assign wr_end = state_q == csp_pkg::DEV_WDATA && rise && byte_end;
   assign rd_end = state_q == csp_pkg::DEV_RDATA && fall && byte_end;

   always_ff @(posedge core_clk)
   begin
      if (rst)
         sclk_prev_q <= 1'b0;
      else
         sclk_prev_q <= sclk_s;
   end

   // Transaction sequencing
   always_ff @(posedge core_clk)
   begin
      if (rst)
         state_q <= csp_pkg::DEV_IDLE;
      else if (sel_n)
         state_q <= csp_pkg::DEV_IDLE;
      else
      begin
         case (state_q)
            csp_pkg::DEV_IDLE:
               state_q <= csp_pkg::DEV_INSTR;
            csp_pkg::DEV_INSTR:
            begin
               if (instr_end)
                  state_q <= in_byte[csp_pkg::INSTR_DIR_BIT] ? csp_pkg::DEV_RDATA : csp_pkg::DEV_WDATA;
            end
            csp_pkg::DEV_WDATA:
            begin
               if (wr_end && left_q == 2'h0)
                  state_q <= csp_pkg::DEV_WAIT;
            end
            csp_pkg::DEV_RDATA:
            begin
               // Final bit stays on the pin for a full clock period
               if (fall && last_q)
                  state_q <= csp_pkg::DEV_WAIT;
            end
            csp_pkg::DEV_WAIT:
               state_q <= csp_pkg::DEV_WAIT;
            default:
               state_q <= csp_pkg::DEV_IDLE;
         endcase
      end
   end

   // Bit counter
   always_ff @(posedge core_clk)
   begin
      if (rst || sel_n || state_q == csp_pkg::DEV_IDLE)
         bit_cnt_q <= 3'h0;
      else if ((state_q == csp_pkg::DEV_INSTR || state_q == csp_pkg::DEV_WDATA) && rise)
         bit_cnt_q <= bit_cnt_q + 3'h1;
      else if (state_q == csp_pkg::DEV_RDATA && fall)
         bit_cnt_q <= bit_cnt_q + 3'h1;
   end

   // Byte count and address
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         left_q <= 2'h0;
         addr_q <= csp_pkg::OPT_REG_ADDR;
      end
      else if (instr_end)
      begin
         left_q <= in_byte[csp_pkg::INSTR_CNT_HI:csp_pkg::INSTR_CNT_LO];
         addr_q <= in_byte[csp_pkg::ADDR_W-1:0];
      end
      else if ((wr_end || rd_end) && left_q != 2'h0)
      begin
         left_q <= left_q - 2'h1;
         addr_q <= next_addr;
      end
   end

   // Input shift register
   always_ff @(posedge core_clk)
   begin
      if (rst || sel_n)
         sh_q <= csp_pkg::REG_RESET;
      else if ((state_q == csp_pkg::DEV_INSTR || state_q == csp_pkg::DEV_WDATA) && rise)
         sh_q <= in_byte;
   end

   // Register file and write notification
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < csp_pkg::NUM_REGS; i++)
            regs_q[i] <= csp_pkg::REG_RESET;
         wr_stb_q <= 1'b0;
         wr_addr_q <= csp_pkg::OPT_REG_ADDR;
         wr_data_q <= csp_pkg::REG_RESET;
      end
      else
      begin
         wr_stb_q <= wr_end;
         if (wr_end)
         begin
            wr_addr_q <= addr_q;
            wr_data_q <= in_byte;
            // Undefined option bits are kept at zero
            if (addr_q == csp_pkg::OPT_REG_ADDR)
               regs_q[addr_q] <= in_byte & csp_pkg::OPT_WRITE_MASK;
            else
               regs_q[addr_q] <= in_byte;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         look_data_q <= csp_pkg::REG_RESET;
      else
         look_data_q <= regs_q[look_addr];
   end

   // Read shifter
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         rsh_q <= csp_pkg::REG_RESET;
         out_q <= 1'b0;
      end
      else if (instr_end && in_byte[csp_pkg::INSTR_DIR_BIT])
         rsh_q <= regs_q[in_byte[csp_pkg::ADDR_W-1:0]];
      // Drive next bit on falling edge
      else if (state_q == csp_pkg::DEV_RDATA && fall && !last_q)
      begin
         out_q <= lsb_first ? rsh_q[0] : rsh_q[7];
         if (byte_end)
            rsh_q <= regs_q[next_addr];
         else if (lsb_first)
            rsh_q <= {1'b0, rsh_q[7:1]};
         else
            rsh_q <= {rsh_q[6:0], 1'b0};
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst || sel_n || state_q == csp_pkg::DEV_IDLE)
         last_q <= 1'b0;
      else if (rd_end && left_q == 2'h0)
         last_q <= 1'b1;
   end

   // Pin drivers
   always_ff @(posedge core_clk)
   begin
      if (rst || sel_n || state_q != csp_pkg::DEV_RDATA)
      begin
         data_io_oe_q <= 1'b0;
         out_pin_oe_q <= 1'b0;
      end
      else if (fall && !last_q)
      begin
         data_io_oe_q <= ~four_wire;
         out_pin_oe_q <= four_wire;
      end
   end

   assign link.data_io_d_o = out_q;
   assign link.data_io_d_oe = data_io_oe_q;
   assign link.serial_data_out_pin_o = out_q;
   assign link.serial_data_out_pin_oe = out_pin_oe_q;
endmodule
`default_nettype wire

// ---- verilog/csp_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module csp_host (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Serial link
   csp_if.host link,
   // Command
   input wire logic cmd_valid,
   output logic cmd_ready_q,
   input wire logic cmd_read,
   input wire csp_pkg::csp_cnt_t cmd_count,
   input wire csp_pkg::csp_addr_t cmd_addr,
   input wire logic [31:0] cmd_wdata,
   input wire logic cfg_lsb_first,
   input wire logic cfg_four_wire,
   // Response
   output logic rsp_valid_q,
   output logic [31:0] rsp_rdata_q
);
   logic [1:0] syn;
   csp_pkg::csp_host_state_t state_q;
   logic [2:0] cnt_q;
   logic [2:0] byte_q;
   csp_pkg::csp_bit_t bit_q;
   logic [1:0] byte_m1;
   logic read_q;
   csp_pkg::csp_cnt_t nbytes_q;
   logic lsb_q;
   logic four_q;
   csp_pkg::csp_byte_t instr_q;
   logic [31:0] wdata_q;
   logic [31:0] rx_q;
   csp_pkg::csp_byte_t cur_byte;
   csp_pkg::csp_bit_t bit_pos;
   logic half_done;
   logic last_bit;
   logic rd_phase;
   logic sclk_q;
   logic sel_n_q;
   logic dout_q;
   logic doe_q;

   csp_sync #(
      .W(2),
      .RST_VAL(csp_pkg::HOST_SYNC_RST)
   ) u_sync (
      .clk(core_clk),
      .rst(rst),
      .d({link.data_io, link.serial_data_out_pin}),
      .q(syn)
   );

   assign half_done = cnt_q == csp_pkg::SCLK_HALF_LAST;
   assign byte_m1 = 2'(byte_q - 3'h1);
   assign cur_byte = (byte_q == 3'h0) ? instr_q : wdata_q[{byte_m1, 3'h0} +: csp_pkg::BYTE_W];
   // Order chosen per command, so each byte goes LSB or MSB first
   assign bit_pos = lsb_q ? bit_q : csp_pkg::BIT_LAST - bit_q;
   assign last_bit = bit_q == csp_pkg::BIT_LAST && byte_q == 3'({1'b0, nbytes_q}) + 3'h1;
   assign rd_phase = read_q && byte_q != 3'h0;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state_q <= csp_pkg::HST_IDLE;
         cnt_q <= 3'h0;
         byte_q <= 3'h0;
         bit_q <= 3'h0;
         sclk_q <= 1'b0;
         sel_n_q <= 1'b1;
         cmd_ready_q <= 1'b0;
         rsp_valid_q <= 1'b0;
      end
      else
      begin
         rsp_valid_q <= 1'b0;
         cnt_q <= half_done ? cnt_q : cnt_q + 3'h1;
         case (state_q)
            csp_pkg::HST_IDLE:
            begin
               cmd_ready_q <= half_done && !(cmd_valid && cmd_ready_q);
               if (cmd_valid && cmd_ready_q)
               begin
                  state_q <= csp_pkg::HST_SETUP;
                  cnt_q <= 3'h0;
                  byte_q <= 3'h0;
                  bit_q <= 3'h0;
                  sel_n_q <= 1'b0;
               end
            end
            csp_pkg::HST_SETUP:
            begin
               if (half_done)
               begin
                  state_q <= csp_pkg::HST_LOW;
                  cnt_q <= 3'h0;
               end
            end
            csp_pkg::HST_LOW:
            begin
               if (half_done)
               begin
                  state_q <= csp_pkg::HST_HIGH;
                  cnt_q <= 3'h0;
                  sclk_q <= 1'b1;
               end
            end
            csp_pkg::HST_HIGH:
            begin
               if (half_done)
               begin
                  cnt_q <= 3'h0;
                  sclk_q <= 1'b0;
                  if (last_bit)
                     state_q <= csp_pkg::HST_END;
                  else
                  begin
                     state_q <= csp_pkg::HST_LOW;
                     bit_q <= bit_q + 3'h1;
                     if (bit_q == csp_pkg::BIT_LAST)
                        byte_q <= byte_q + 3'h1;
                  end
               end
            end
            csp_pkg::HST_END:
            begin
               if (half_done)
               begin
                  state_q <= csp_pkg::HST_IDLE;
                  cnt_q <= 3'h0;
                  sel_n_q <= 1'b1;
                  rsp_valid_q <= 1'b1;
               end
            end
            default:
               state_q <= csp_pkg::HST_IDLE;
         endcase
      end
   end

   // Command capture
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         read_q <= 1'b0;
         nbytes_q <= 2'h0;
         lsb_q <= 1'b0;
         four_q <= 1'b0;
         instr_q <= csp_pkg::REG_RESET;
         wdata_q <= 32'h0000_0000;
      end
      else if (state_q == csp_pkg::HST_IDLE && cmd_valid && cmd_ready_q)
      begin
         read_q <= cmd_read;
         nbytes_q <= cmd_count;
         lsb_q <= cfg_lsb_first;
         four_q <= cfg_four_wire;
         instr_q <= {cmd_read, cmd_count, cmd_addr};
         wdata_q <= cmd_wdata;
      end
   end

   // Data pin drive, changed just after each falling edge
   always_ff @(posedge core_clk)
   begin
      if (rst || state_q == csp_pkg::HST_IDLE || state_q == csp_pkg::HST_END)
      begin
         dout_q <= 1'b0;
         doe_q <= 1'b0;
      end
      else if (state_q == csp_pkg::HST_LOW && cnt_q == 3'h0)
      begin
         // Write bits set up before rise
         dout_q <= cur_byte[bit_pos];
         doe_q <= ~rd_phase;
      end
   end

   // Read capture late in the high phase, after the device's update has settled
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         rx_q <= 32'h0000_0000;
         rsp_rdata_q <= 32'h0000_0000;
      end
      else if (state_q == csp_pkg::HST_IDLE && cmd_valid && cmd_ready_q)
         rx_q <= 32'h0000_0000;
      else if (state_q == csp_pkg::HST_HIGH && half_done && rd_phase)
         rx_q[{byte_m1, bit_pos}] <= four_q ? syn[0] : syn[1];
      else if (state_q == csp_pkg::HST_END && half_done)
         rsp_rdata_q <= rx_q;
   end

   assign link.sclk = sclk_q;
   assign link.port_select_n = sel_n_q;
   assign link.data_io_h_o = dout_q;
   assign link.data_io_h_oe = doe_q;
endmodule
`default_nettype wire

// ---- verification/csp_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module csp_sva (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Link signals
   input wire logic sclk,
   input wire logic port_select_n,
   input wire logic data_io_h_oe,
   input wire logic data_io_d_o,
   input wire logic data_io_d_oe,
   input wire logic serial_data_out_pin_o,
   input wire logic serial_data_out_pin_oe
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   logic sclk_q;
   logic [5:0] rise_cnt_q;
   // Counted straight off the pin, so no synchroniser lag
   always_ff @(posedge core_clk)
   begin
      sclk_q <= sclk;
      if (rst || port_select_n)
         rise_cnt_q <= 6'h00;
      else if (sclk && !sclk_q)
         rise_cnt_q <= rise_cnt_q + 6'h01;
   end
   property p_sel_release;
      port_select_n [*5] |-> !data_io_d_oe && !serial_data_out_pin_oe;
   endproperty
   a_sel_release: assert property (p_sel_release) else $error("pin driven while deselected");
   property p_one_pin;
      !(data_io_d_oe && serial_data_out_pin_oe);
   endproperty
   a_one_pin: assert property (p_one_pin) else $error("both read pins driven");
   property p_no_fight;
      !(data_io_d_oe && data_io_h_oe);
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("data pin driven by both ends");
   property p_fall_change;
      (data_io_d_oe && $past(data_io_d_oe) && $changed(data_io_d_o)) ||
      (serial_data_out_pin_oe && $past(serial_data_out_pin_oe) && $changed(serial_data_out_pin_o)) |-> !sclk;
   endproperty
   a_fall_change: assert property (p_fall_change) else $error("read bit changed in high phase");
   property p_first_bit;
      $rose(data_io_d_oe) || $rose(serial_data_out_pin_oe) |-> rise_cnt_q == 6'h08 && !sclk;
   endproperty
   a_first_bit: assert property (p_first_bit) else $error("read data not right after header");
   property p_hdr_drive;
      sclk && !sclk_q && !port_select_n && rise_cnt_q < 6'h08 |-> data_io_h_oe;
   endproperty
   a_hdr_drive: assert property (p_hdr_drive) else $error("header bit not driven at rise");
   property p_frame_len;
      $rose(port_select_n) |-> rise_cnt_q[2:0] == 3'h0 && rise_cnt_q >= 6'h10 && rise_cnt_q <= 6'h28;
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame not whole bytes");
   property p_count_max;
      data_io_d_oe || serial_data_out_pin_oe |-> rise_cnt_q <= 6'h28;
   endproperty
   a_count_max: assert property (p_count_max) else $error("read beyond four bytes");
   property p_sdo_data;
      serial_data_out_pin_oe && !port_select_n |-> ##0 rise_cnt_q >= 6'h08;
   endproperty
   a_sdo_data: assert property (p_sdo_data) else $error("output pin driven in header");
   c_four_wire: cover property ($rose(serial_data_out_pin_oe));
   c_three_wire: cover property ($rose(data_io_d_oe));
   c_long_frame: cover property ($rose(port_select_n) && rise_cnt_q == 6'h28);
endmodule
`default_nettype wire

// ---- verification/test_config_serial_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_config_serial_port;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic cmd_valid = 1'b0;
   logic cmd_read = 1'b0;
   csp_pkg::csp_cnt_t cmd_count = 2'h0;
   csp_pkg::csp_addr_t cmd_addr = 5'h00;
   logic [31:0] cmd_wdata = 32'h00000000;
   logic cfg_lsb_first = 1'b0;
   logic cfg_four_wire = 1'b0;
   csp_pkg::csp_addr_t look_addr = 5'h00;
   logic cmd_ready_q, rsp_valid_q, wr_stb_q, four_wire, lsb_first, seen_d, seen_s;
   logic [31:0] rsp_rdata_q, r, wd;
   csp_pkg::csp_byte_t look_data_q, wr_data_q;
   csp_pkg::csp_addr_t wr_addr_q;
   csp_pkg::csp_cnt_t c;
   csp_pkg::csp_byte_t model_q [32];
   logic [7:0] hdr_seen;
   int bit_n, n_stb, n_errors, n_compared;
   integer seed = 99621;
   always #(csp_pkg::CORE_PERIOD_NS / 2) core_clk = ~core_clk;
   csp_if csp_if_i ();
   csp_device csp_device_i (.core_clk(core_clk), .rst(rst), .link(csp_if_i), .look_addr(look_addr),
      .look_data_q(look_data_q), .wr_stb_q(wr_stb_q), .wr_addr_q(wr_addr_q), .wr_data_q(wr_data_q),
      .four_wire(four_wire), .lsb_first(lsb_first));
   csp_host csp_host_i (.core_clk(core_clk), .rst(rst), .link(csp_if_i), .cmd_valid(cmd_valid),
      .cmd_ready_q(cmd_ready_q), .cmd_read(cmd_read), .cmd_count(cmd_count), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cfg_lsb_first(cfg_lsb_first), .cfg_four_wire(cfg_four_wire),
      .rsp_valid_q(rsp_valid_q), .rsp_rdata_q(rsp_rdata_q));
   csp_sva csp_sva_i (.core_clk(core_clk), .rst(rst), .sclk(csp_if_i.sclk), .port_select_n(csp_if_i.port_select_n),
      .data_io_h_oe(csp_if_i.data_io_h_oe), .data_io_d_o(csp_if_i.data_io_d_o), .data_io_d_oe(csp_if_i.data_io_d_oe),
      .serial_data_out_pin_o(csp_if_i.serial_data_out_pin_o),
      .serial_data_out_pin_oe(csp_if_i.serial_data_out_pin_oe));
   // Wire monitor: header bits and frame length
   always @(negedge csp_if_i.port_select_n)
      bit_n = 0;
   always @(posedge csp_if_i.sclk)
   begin
      if (!csp_if_i.port_select_n)
      begin
         if (bit_n < 8)
            hdr_seen = {hdr_seen[6:0], csp_if_i.data_io};
         bit_n++;
      end
   end
   // Cleared while a command waits, so only one frame is seen
   always @(posedge core_clk)
   begin
      if (cmd_valid)
      begin
         seen_d <= 1'b0;
         seen_s <= 1'b0;
         n_stb <= 0;
      end
      else
      begin
         seen_d <= seen_d | csp_if_i.data_io_d_oe;
         seen_s <= seen_s | csp_if_i.serial_data_out_pin_oe;
         n_stb <= n_stb + int'(wr_stb_q === 1'b1);
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_compared++;
      if (seen !== want)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic final_report();
      if (n_errors == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   function automatic logic [7:0] rev8(input logic [7:0] v);
      for (int k = 0; k < 8; k++)
         rev8[k] = v[7 - k];
   endfunction
   task automatic check_regs();
      for (int k = 0; k < 32; k++)
      begin
         look_addr = 5'(k);
         @(negedge core_clk);
         @(negedge core_clk);
         check(look_data_q, model_q[k]);
      end
      check({four_wire, lsb_first}, model_q[0][7:6]);
      check({csp_if_i.data_io, csp_if_i.serial_data_out_pin}, 2'h3);
   endtask
   task automatic xfer(input logic rd, input csp_pkg::csp_cnt_t cnt, input csp_pkg::csp_addr_t addr,
      input logic [31:0] wdata);
      logic [31:0] want;
      csp_pkg::csp_addr_t a;
      logic l, f;
      int i;
      want = 32'h00000000;
      l = model_q[0][6];
      f = model_q[0][7];
      i = 0;
      @(negedge core_clk);
      cmd_read = rd;
      cmd_count = cnt;
      cmd_addr = addr;
      cmd_wdata = wdata;
      cfg_lsb_first = l;
      cfg_four_wire = f;
      cmd_valid = 1'b1;
      while (cmd_ready_q !== 1'b1 && i < 2000)
      begin
         @(negedge core_clk);
         i++;
      end
      @(negedge core_clk);
      cmd_valid = 1'b0;
      while (rsp_valid_q !== 1'b1 && i < 2000)
      begin
         @(negedge core_clk);
         i++;
      end
      check(i < 2000, 1'b1);
      if (i >= 2000)
         final_report();
      for (i = 0; i <= cnt; i++)
      begin
         a = l ? addr + 5'(i) : addr - 5'(i);
         if (rd)
            want[8*i +: 8] = model_q[a];
         else
            model_q[a] = (a == csp_pkg::OPT_REG_ADDR) ? wdata[8*i +: 8] & csp_pkg::OPT_WRITE_MASK : wdata[8*i +: 8];
      end
      check(hdr_seen, l ? rev8({rd, cnt, addr}) : {rd, cnt, addr});
      check(bit_n, 8 * (cnt + 2));
      // Writes must hand back all zeros
      check(rsp_rdata_q, want);
      if (rd)
         check({seen_d, seen_s}, {!f, f});
      else
      begin
         check({seen_d, seen_s}, 2'h0);
         check(n_stb, cnt + 1);
         check({wr_addr_q, wr_data_q}, {a, wdata[8*cnt +: 8]});
      end
      check_regs();
   endtask
   initial
   begin
      for (int k = 0; k < 32; k++)
         model_q[k] = csp_pkg::REG_RESET;
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      check_regs();
      // Mode flips on the last byte; wrap both ways
      xfer(1'b0, 2'h1, 5'h01, 32'h0000C05A);
      xfer(1'b1, 2'h3, 5'h00, 32'h00000000);
      xfer(1'b0, 2'h1, 5'h1F, 32'h000040A5);
      xfer(1'b1, 2'h3, 5'h1E, 32'h00000000);
      xfer(1'b0, 2'h0, 5'h00, 32'h00000080);
      xfer(1'b1, 2'h3, 5'h01, 32'h00000000);
      xfer(1'b0, 2'h0, 5'h00, 32'h00000000);
      // Three-wire read in MSB order, stepping down from 1 to 0
      xfer(1'b1, 2'h1, 5'h01, 32'h00000000);
      repeat (16)
      begin
         r = $random(seed);
         wd = $random(seed);
         c = r[1:0];
         // undefined bits zero, option register only as last byte of a write
         for (int k = 0; k <= c; k++)
         begin
            if (5'(model_q[0][6] ? r[6:2] + k : r[6:2] - k) == 5'h00)
            begin
               wd[8*k +: 8] = wd[8*k +: 8] & csp_pkg::OPT_WRITE_MASK;
               if (!r[7])
                  c = 2'(k);
            end
         end
         xfer(r[7], c, r[6:2], wd);
      end
      final_report();
   end
endmodule
`default_nettype wire
